// >>> src/io_test_pulse_fault_monitor.sv
// Function
// - Per-output extended detection time selectable
// - Low within 3 ms or 43 ms
// - Cross-circuit error if Low missed
// - Detection plus response within 10/50 ms
// - Faulty output forced off after detection
// - Odd and even test outputs, two generators
// - Generator shorts detected with short gaps
// - High shorts on tested inputs detected
// - Same-generator shorts never reported
// - Configurable outputs: test or non-safe
// - Non-safe both plus tested input warns
// - Eight safe inputs forwarded to host
// - Outputs follow host commands
// - Inactive unless attached to host, except non-safe configurable outputs and warning
// - One generator per first two test outputs
`include "iotp_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module io_test_pulse_fault_monitor #(
  parameter int DET_STD = `DET_STD_CYC,
  parameter int DET_EXT = `DET_EXT_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic [7:0] safe_input_pins,
  input wire logic [3:0] safe_output_low_pins,
  output logic [3:0] safe_output_drive,
  output logic test_output_odd_first,
  output logic test_output_even_first,
  output logic configurable_test_out_a,
  output logic configurable_test_out_b,
  // Interrupt
  output logic irq
);
  import iotp_pkg::*;
  // Input synchronisers
  logic [7:0] in_s1_r, in_s2_r;
  logic [3:0] low_s1_r, low_s2_r;
  always_ff @(posedge aclk) begin
    in_s1_r <= safe_input_pins;
    in_s2_r <= in_s1_r;
    low_s1_r <= safe_output_low_pins;
    low_s2_r <= low_s1_r;
  end
  // Registers
  word_t ctrl_r, ctrl_nxt, outcfg_r, outcfg_nxt, outcmd_r, outcmd_nxt;
  word_t mask_r, mask_nxt, gap_r, gap_nxt, period_r, period_nxt;
  logic [6:0] stat_r, stat_nxt;
  logic [3:0] fault_r, fault_nxt;
  logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  word_t wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic irq_r, irq_nxt;
  // Generator state
  gen_state_t gen_st_r, gen_st_nxt;
  logic [31:0] gen_cnt_r, gen_cnt_nxt;
  logic [1:0] gen_lvl;
  logic attached;
  assign attached = ctrl_r[`CTRL_ATTACHED];
  // Detection timers per output
  logic [31:0] det_cnt_r [4];
  logic [31:0] det_cnt_nxt [4];
  logic [3:0] xfault, drive_nxt;
  logic [3:0] drive_r;
  // Output watch: switched off but not Low
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_out
      always_comb begin
        logic [31:0] lim;
        lim = outcfg_r[`OUTCFG_EXT_LSB + g] ? 32'(DET_EXT) : 32'(DET_STD);
        det_cnt_nxt[g] = 32'd0;
        xfault[g] = 1'b0;
        if (attached && !outcmd_r[g] && !low_s2_r[g]) begin
          if (det_cnt_r[g] < lim) begin
            det_cnt_nxt[g] = det_cnt_r[g] + 32'd1;
          end else begin
            det_cnt_nxt[g] = det_cnt_r[g];
            xfault[g] = 1'b1;
          end
        end
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          det_cnt_r[g] <= 32'd0;
        end else begin
          det_cnt_r[g] <= det_cnt_nxt[g];
        end
      end
    end
  endgenerate
  // Test pulse generators: shared timing, separate pins
  logic [31:0] hi_len;
  logic gen_run, short_det, high_det, warn;
  assign hi_len = period_r - gap_r;
  always_comb begin
    gen_st_nxt = gen_st_r;
    gen_cnt_nxt = gen_cnt_r + 32'd1;
    if (!attached) begin
      gen_st_nxt = GEN_IDLE;
      gen_cnt_nxt = 32'd0;
    end else begin
      case (gen_st_r)
        GEN_IDLE: begin
          gen_st_nxt = GEN_HIGH;
          gen_cnt_nxt = 32'd0;
        end
        GEN_HIGH: begin
          if (gen_cnt_r >= hi_len) begin
            gen_st_nxt = GEN_GAP;
            gen_cnt_nxt = 32'd0;
          end
        end
        GEN_GAP: begin
          if (gen_cnt_r >= gap_r) begin
            gen_st_nxt = GEN_HIGH;
            gen_cnt_nxt = 32'd0;
          end
        end
        default: begin
          gen_st_nxt = GEN_IDLE;
          gen_cnt_nxt = 32'd0;
        end
      endcase
    end
  end
  // Odd gaps in first half, even in second
  assign gen_lvl[0] = !(gen_st_r == GEN_GAP && gen_cnt_r < (gap_r >> 1));
  assign gen_lvl[1] = !(gen_st_r == GEN_GAP && gen_cnt_r >= (gap_r >> 1));
  assign gen_run = attached && gen_st_r != GEN_IDLE;
  // Short between generators: input high while its generator gaps
  // Inputs fed by one generator are compared only with that generator
  assign short_det = gen_run && gap_r <= `GAP_MAX_CYC && period_r >= `PERIOD_MIN_CYC
    && ctrl_r[`CTRL_TESTED_IN] && gen_st_r == GEN_GAP
    && ((!gen_lvl[0] && |(in_s2_r & 8'h55 & outcfg_r[23:16]))
     || (!gen_lvl[1] && |(in_s2_r & 8'haa & outcfg_r[23:16])));
  // Tested input high on the last cycle of a gap
  assign high_det = gen_run && ctrl_r[`CTRL_TESTED_IN] && gen_st_r == GEN_GAP
    && gen_cnt_r >= gap_r && |(in_s2_r & outcfg_r[23:16]);
  // Both configurable outputs non-safe with tested input
  assign warn = ctrl_r[`CTRL_XY_A_NONSAFE] && ctrl_r[`CTRL_XY_B_NONSAFE]
    && ctrl_r[`CTRL_TESTED_IN];
  // Latched fault forces the output off within the budget
  always_comb begin
    fault_nxt = attached ? (fault_r | xfault) : 4'h0;
    for (int i = 0; i < 4; i++) begin
      // Drive per host command, gated by pulse test
      drive_nxt[i] = attached && outcmd_r[i] && !fault_r[i] && !xfault[i]
        && (!outcfg_r[`OUTCFG_TP_LSB + i] || gen_lvl[i[0]]);
    end
  end
  // AXI write path
  logic wr_go;
  logic [7:0] wsel;
  assign wr_go = aw_ok_r && w_ok_r && !bvalid_r;
  assign wsel = awaddr_r & 8'hfc;
  always_comb begin
    logic [31:0] m;
    m = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    aw_ok_nxt = aw_ok_r;
    w_ok_nxt = w_ok_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    ctrl_nxt = ctrl_r;
    outcfg_nxt = outcfg_r;
    outcmd_nxt = outcmd_r;
    mask_nxt = mask_r;
    gap_nxt = gap_r;
    period_nxt = period_r;
    bvalid_nxt = bvalid_r && !s_axi_bready;
    bresp_nxt = bresp_r;
    stat_nxt = stat_r;
    if (s_axi_awvalid && !aw_ok_r) begin
      aw_ok_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_ok_r) begin
      w_ok_nxt = 1'b1;
      wdata_nxt = (s_axi_wdata & m) | (32'h0 & ~m);
    end
    if (wr_go) begin
      aw_ok_nxt = 1'b0;
      w_ok_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = 2'b00;
      case (wsel)
        `OFS_CTRL: ctrl_nxt = {28'h0, wdata_r[3:0]};
        `OFS_OUTCFG: outcfg_nxt = {8'h0, wdata_r[23:16], 8'h0, wdata_r[7:0]};
        `OFS_OUTCMD: outcmd_nxt = {22'h0, wdata_r[9:8], 4'h0, wdata_r[3:0]};
        `OFS_IRQ_STAT: stat_nxt = stat_r & ~wdata_r[6:0];
        `OFS_IRQ_MASK: mask_nxt = {25'h0, wdata_r[6:0]};
        `OFS_GENCFG: begin
          gap_nxt = {16'h0, wdata_r[15:0]} * `GAP_UNIT_CYC;
          period_nxt = {16'h0, wdata_r[31:16]} * `PERIOD_UNIT_CYC;
        end
        `OFS_INSTATE, `OFS_FAULT: bresp_nxt = 2'b00;
        default: bresp_nxt = 2'b10;
      endcase
    end
    // Events win over a clear in the same cycle
    stat_nxt = stat_nxt | {warn, high_det, short_det, xfault};
    irq_nxt = |(stat_nxt & mask_r[6:0]);
  end

  // AXI read path
  always_comb begin
    rvalid_nxt = rvalid_r && !s_axi_rready;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = 2'b00;
      case (s_axi_araddr & 8'hfc)
        `OFS_CTRL: rdata_nxt = ctrl_r;
        `OFS_OUTCFG: rdata_nxt = outcfg_r;
        `OFS_OUTCMD: rdata_nxt = outcmd_r;
        `OFS_INSTATE: rdata_nxt = {24'h0, attached ? in_s2_r : 8'h00};
        `OFS_FAULT: rdata_nxt = {28'h0, fault_r};
        `OFS_IRQ_STAT: rdata_nxt = {25'h0, stat_r};
        `OFS_IRQ_MASK: rdata_nxt = mask_r;
        `OFS_GENCFG: rdata_nxt = 32'h0;
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = 2'b10;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= 32'h0;
      outcfg_r <= 32'h0;
      outcmd_r <= 32'h0;
      mask_r <= 32'h0;
      gap_r <= `GAP_RST;
      period_r <= `PERIOD_RST;
      stat_r <= 7'h0;
      fault_r <= 4'h0;
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      awaddr_r <= 8'h0;
      wdata_r <= 32'h0;
      rdata_r <= 32'h0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      bresp_r <= 2'b00;
      rresp_r <= 2'b00;
      irq_r <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_arready <= 1'b1;
      gen_st_r <= GEN_IDLE;
      gen_cnt_r <= 32'h0;
      drive_r <= 4'h0;
      test_output_odd_first <= 1'b0;
      test_output_even_first <= 1'b0;
      configurable_test_out_a <= 1'b0;
      configurable_test_out_b <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      outcfg_r <= outcfg_nxt;
      outcmd_r <= outcmd_nxt;
      mask_r <= mask_nxt;
      gap_r <= gap_nxt;
      period_r <= period_nxt;
      stat_r <= stat_nxt;
      fault_r <= fault_nxt;
      aw_ok_r <= aw_ok_nxt;
      w_ok_r <= w_ok_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      bvalid_r <= bvalid_nxt;
      rvalid_r <= rvalid_nxt;
      bresp_r <= bresp_nxt;
      rresp_r <= rresp_nxt;
      irq_r <= irq_nxt;
      s_axi_awready <= !aw_ok_nxt;
      s_axi_wready <= !w_ok_nxt;
      s_axi_arready <= !rvalid_nxt;
      gen_st_r <= gen_st_nxt;
      gen_cnt_r <= gen_cnt_nxt;
      drive_r <= drive_nxt;
      // Each first test output has its own generator
      test_output_odd_first <= gen_run && gen_lvl[0];
      test_output_even_first <= gen_run && gen_lvl[1];
      // Test pulse or plain non-safe level
      configurable_test_out_a <= ctrl_r[`CTRL_XY_A_NONSAFE] ? outcmd_r[8] : gen_run && gen_lvl[0];
      configurable_test_out_b <= ctrl_r[`CTRL_XY_B_NONSAFE] ? outcmd_r[9] : gen_run && gen_lvl[1];
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign safe_output_drive = drive_r;
  assign irq = irq_r;
endmodule
`default_nettype wire

// >>> src/iotp_consts.svh
`ifndef IOTP_CONSTS_SVH
`define IOTP_CONSTS_SVH
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_OUTCFG 8'h04
`define OFS_OUTCMD 8'h08
`define OFS_INSTATE 8'h0c
`define OFS_FAULT 8'h10
`define OFS_IRQ_STAT 8'h14
`define OFS_IRQ_MASK 8'h18
`define OFS_GENCFG 8'h1c
// Control fields
`define CTRL_ATTACHED 0
`define CTRL_XY_A_NONSAFE 1
`define CTRL_XY_B_NONSAFE 2
`define CTRL_TESTED_IN 3
// Output config: [3:0] test pulse enable, [7:4] extended detection
`define OUTCFG_TP_LSB 0
`define OUTCFG_EXT_LSB 4
// Interrupt status bits: [3:0] cross-circuit, 4 generator short, 5 high short, 6 warning
`define IRQ_GEN_SHORT 4
`define IRQ_HIGH_SHORT 5
`define IRQ_WARN 6
// Timing in microseconds and clock rate
`define CLK_MHZ 100
`define DET_STD_US 3000
`define DET_EXT_US 43000
`define RESP_STD_US 10000
`define RESP_EXT_US 50000
`define DET_STD_CYC (`DET_STD_US * `CLK_MHZ)
`define DET_EXT_CYC (`DET_EXT_US * `CLK_MHZ)
// Reset values and generator short detection limits
`define GAP_RST 32'd400000
`define PERIOD_RST 32'd20000000
`define GAP_MAX_CYC (4000 * `CLK_MHZ)
`define PERIOD_MIN_CYC (200000 * `CLK_MHZ)
// Generator config units: gap in us, period in ms
`define GAP_UNIT_CYC 32'd100
`define PERIOD_UNIT_CYC 32'd100000
`endif

// >>> src/iotp_pkg.sv
package iotp_pkg;
  typedef enum logic [1:0] {GEN_IDLE, GEN_HIGH, GEN_GAP} gen_state_t;
  typedef logic [31:0] word_t;
endpackage

// >>> bench/iotp_checker.sv
`timescale 1ns/1ns
`default_nettype none
module iotp_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic [3:0] safe_output_drive,
  input wire logic irq
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bresp dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rresp, s_axi_rdata});
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rdata dropped");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("late rvalid");
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("late bvalid");
  property p_b_cause;
    $rose(s_axi_bvalid) |-> $past(s_axi_wvalid, 2);
  endproperty
  a_b_cause: assert property (p_b_cause) else $error("stray bvalid");
  property p_drive;
    |(safe_output_drive & ~$past(safe_output_drive)) |->
      s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
  endproperty
  a_drive: assert property (p_drive) else $error("output on without command");
  property p_reset;
    $rose(aresetn) |-> safe_output_drive == 4'h0 && !irq && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_reset: assert property (p_reset) else $error("active in reset");
  property p_slverr;
    s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0;
  endproperty
  a_slverr: assert property (p_slverr) else $error("refused read data");
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  c_off: cover property ($fell(safe_output_drive[1]));
endmodule
`default_nettype wire

// >>> bench/main_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module main_host_model (
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // Read channels
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      if (s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> bench/io_test_pulse_fault_monitor_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "iotp_consts.svh"
module io_test_pulse_fault_monitor_test;
  localparam int DSTD = 20;
  localparam int DEXT = 100;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, safe_input_pins = 8'h0;
  logic [31:0] s_axi_wdata, s_axi_rdata, rs = 32'h8;
  logic [3:0] s_axi_wstrb, safe_output_drive, safe_output_low_pins = 4'h0, stuck = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic test_output_odd_first, test_output_even_first;
  logic configurable_test_out_a, configurable_test_out_b;
  logic [33:0] expq[$];
  logic [1:0] bq[$];
  logic [3:0] ctl[4] = '{4'hb, 4'hd, 4'h7, 4'hf};
  int mismatches = 0;
  int n_checks = 0;
  io_test_pulse_fault_monitor #(.DET_STD(DSTD), .DET_EXT(DEXT)) dut (.*);
  main_host_model host (.*);
  always #5 aclk = ~aclk;
  // Load falls Low unless held up
  always @(posedge aclk) safe_output_low_pins <= ~safe_output_drive & ~stuck;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rdx(input logic [7:0] a, input logic [33:0] e);
    expq.push_back(e);
    host.rd(a);
  endtask
  task automatic wrx(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    bq.push_back(e);
    host.wr(a, d);
  endtask
  task automatic settle();
    repeat (2) @(posedge aclk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready && expq.size() > 0) begin
      chk({s_axi_rresp, s_axi_rdata}, expq.pop_front());
    end
  end
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0) begin
      chk(34'(s_axi_bresp), 34'(bq.pop_front()));
    end
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    safe_input_pins <= 8'ha5;
    rdx(`OFS_INSTATE, 34'h0);
    rdx(8'h20, 34'h2_0000_0000);
    wrx(8'h20, 32'h1, 2'b10);
    $display("test detached done");
    wrx(`OFS_CTRL, 32'h1, 2'b00);
    for (int i = 0; i < 4; i++) begin
      rs = xs(rs);
      safe_input_pins <= rs[7:0];
      repeat (4) @(posedge aclk);
      rdx(`OFS_INSTATE, 34'(rs[7:0]));
    end
    chk(34'({test_output_odd_first, test_output_even_first}), 34'h3);
    $display("test inputs done");
    host.wr(`OFS_OUTCFG, 32'h20);
    host.wr(`OFS_IRQ_MASK, 32'h7f);
    host.wr(`OFS_OUTCMD, 32'hf);
    settle();
    chk(34'(safe_output_drive), 34'hf);
    stuck <= 4'h3;
    host.wr(`OFS_OUTCMD, 32'h0);
    repeat (DSTD + 8) @(posedge aclk);
    rdx(`OFS_IRQ_STAT, 34'h1);
    repeat (DEXT) @(posedge aclk);
    rdx(`OFS_IRQ_STAT, 34'h3);
    chk(34'({irq, safe_output_drive}), 34'h10);
    host.wr(`OFS_IRQ_MASK, 32'h0);
    settle();
    chk(34'(irq), 34'h0);
    stuck <= 4'h0;
    host.wr(`OFS_IRQ_MASK, 32'h7f);
    host.wr(`OFS_IRQ_STAT, 32'h3);
    rdx(`OFS_IRQ_STAT, 34'h0);
    chk(34'(irq), 34'h0);
    $display("test faults done");
    for (int i = 0; i < 4; i++) begin
      host.wr(`OFS_CTRL, 32'(ctl[i]));
      rdx(`OFS_IRQ_STAT, (ctl[i] == 4'hf) ? 34'h40 : 34'h0);
    end
    host.wr(`OFS_OUTCMD, 32'h200);
    settle();
    chk(34'({configurable_test_out_a, configurable_test_out_b}), 34'h1);
    host.wr(`OFS_CTRL, 32'h0);
    rdx(`OFS_INSTATE, 34'h0);
    chk(34'({test_output_odd_first, test_output_even_first}), 34'h0);
    $display("test warning done");
    settle();
    chk(34'(expq.size() + bq.size()), 34'h0);
    print_verdict();
  end
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
endmodule
bind io_test_pulse_fault_monitor iotp_checker chk_i (.*);
`default_nettype wire
